// ===== hdl/mam_pkg.sv
// Shared constants, types and helpers of the monitor alert mask logic.
package mam_pkg;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int MAM_W = 16;
  localparam int BIT_SHUNT_OVER = 15;
  localparam int BIT_SHUNT_UNDER = 14;
  localparam int BIT_BUS_OVER = 13;
  localparam int BIT_BUS_UNDER = 12;
  localparam int BIT_POWER_OVER = 11;
  localparam int BIT_READY_PIN = 10;
  localparam int BIT_STORAGE_FAULT = 5;
  localparam int BIT_LIMIT_HIT = 4;
  localparam int BIT_RESULT_READY = 3;
  localparam int BIT_MATH_OVF = 2;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_LATCH = 0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic PIN_IDLE_LEVEL = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Which single limit comparison watches the alert pin.
  typedef enum logic [2:0]
  {
    MAM_SEL_NONE,
    MAM_SEL_SHUNT_OVER,
    MAM_SEL_SHUNT_UNDER,
    MAM_SEL_BUS_OVER,
    MAM_SEL_BUS_UNDER,
    MAM_SEL_POWER_OVER
  } mam_sel_t;

  // Last completed results handed over by the measurement datapath.
  typedef struct packed
  {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
  } mam_results_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The highest enabled limit bit wins; lower ones are refused.
  function automatic mam_sel_t mam_first_sel(input logic [15:0] v);
    mam_sel_t s;
    s = MAM_SEL_NONE;
    if (v[BIT_SHUNT_OVER])
      s = MAM_SEL_SHUNT_OVER;
    else if (v[BIT_SHUNT_UNDER])
      s = MAM_SEL_SHUNT_UNDER;
    else if (v[BIT_BUS_OVER])
      s = MAM_SEL_BUS_OVER;
    else if (v[BIT_BUS_UNDER])
      s = MAM_SEL_BUS_UNDER;
    else if (v[BIT_POWER_OVER])
      s = MAM_SEL_POWER_OVER;
    return s;
  endfunction

  // Strict above-threshold test, signed for shunt, unsigned otherwise.
  function automatic logic mam_above(input logic [15:0] a, input logic [15:0] b, input logic is_signed);
    logic r;
    r = is_signed ? ($signed(a) > $signed(b)) : (a > b);
    return r;
  endfunction

endpackage

// ===== hdl/mam_limit_cmp.sv
// Limit comparator of the monitor alert mask logic.
`timescale 1ns/1ps
`default_nettype none

module mam_limit_cmp
#(
  parameter int W = mam_pkg::MAM_W
)
(
  // Selection and operands.
  input wire mam_pkg::mam_sel_t i_sel,
  input wire mam_pkg::mam_results_t i_res,
  input wire logic [W-1:0] i_limit,
  // Comparison outcome.
  output logic o_hit
);

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------
  // Only the selected comparison is ever computed onto the output.
  always_comb
  begin
    o_hit = 1'b0;
    case (i_sel)
      mam_pkg::MAM_SEL_SHUNT_OVER: o_hit = mam_pkg::mam_above(i_res.shunt, i_limit, 1'b1);
      mam_pkg::MAM_SEL_SHUNT_UNDER: o_hit = mam_pkg::mam_above(i_limit, i_res.shunt, 1'b1);
      mam_pkg::MAM_SEL_BUS_OVER: o_hit = mam_pkg::mam_above(i_res.bus, i_limit, 1'b0);
      mam_pkg::MAM_SEL_BUS_UNDER: o_hit = mam_pkg::mam_above(i_limit, i_res.bus, 1'b0);
      mam_pkg::MAM_SEL_POWER_OVER: o_hit = mam_pkg::mam_above(i_res.power, i_limit, 1'b0);
      default: o_hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ===== hdl/mam_alert.sv
// Alert, mask/enable register and status flags of the monitor.
//
// What this block does
// - Shunt over-limit enable alerts on high shunt.
// - Shunt under-limit refused while shunt over set.
// - Bus over-limit alerts; blocked by shunt enables.
// - Bus under-limit alerts; blocked by higher enables.
// - Power over-limit alerts; blocked by all others.
// - Ready-to-pin enable puts ready flag on pin.
// - One limit comparison, ready flag may combine.
// - Limit hit flag marks limit-caused alerts.
// - Latched mode: register read clears hit flag.
// - Transparent: next clean conversion clears hit flag.
// - Ready flag set when whole cycle completes.
// - Config write (not power-down) or register read clears ready.
// - Results stay readable whatever ready flag shows.
// - Arithmetic overflow sets the math overflow flag.
// - Polarity: open-drain low or active-high drive.
// - Transparent: pin and flag idle once clean.
// - Latched: pin and flag hold until read.
`timescale 1ns/1ps
`default_nettype none

module mam_alert
#(
  parameter int W = mam_pkg::MAM_W
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Mask/enable register port.
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  // Configuration register write notice.
  input wire logic i_cfg_wr,
  input wire logic i_cfg_pdown,
  // Measurement datapath.
  input wire logic i_conv_done,
  input wire mam_pkg::mam_results_t i_res,
  input wire logic [W-1:0] i_limit,
  input wire logic i_math_ovf,
  input wire logic i_mem_err,
  // Alert pin.
  output logic o_alert_o,
  output logic o_alert_oe
);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  mam_pkg::mam_sel_t limit_sel;
  logic ready_to_pin_en;
  logic pin_polarity_sel;
  logic pin_latch_sel;
  logic limit_hit_flag;
  logic result_ready_flag;
  logic math_overflow_flag;
  logic storage_fault_flag;
  logic cmp_hit;
  logic alert_active;
  logic [15:0] next_rdata;

  // A write keeps only the highest-ranked limit enable it carries.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      limit_sel <= mam_pkg::MAM_SEL_NONE;
      ready_to_pin_en <= mam_pkg::MASK_RESET[mam_pkg::BIT_READY_PIN];
      pin_polarity_sel <= mam_pkg::MASK_RESET[mam_pkg::BIT_POLARITY];
      pin_latch_sel <= mam_pkg::MASK_RESET[mam_pkg::BIT_LATCH];
    end
    else if (i_reg_wr)
    begin
      limit_sel <= mam_pkg::mam_first_sel(i_reg_wdata);
      ready_to_pin_en <= i_reg_wdata[mam_pkg::BIT_READY_PIN];
      pin_polarity_sel <= i_reg_wdata[mam_pkg::BIT_POLARITY];
      pin_latch_sel <= i_reg_wdata[mam_pkg::BIT_LATCH];
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison
  // ----------------------------------------------------------------
  // The results are sampled only on completion; they are never gated
  // by the ready flag, so software may read them at any time.
  mam_limit_cmp
  #(
    .W(W)
  )
  u_cmp
  (
    .i_sel(limit_sel),
    .i_res(i_res),
    .i_limit(i_limit),
    .o_hit(cmp_hit)
  );

  // Latched mode holds the flag until a read; a hit in the same
  // cycle as the read wins, so no event is lost.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      limit_hit_flag <= mam_pkg::MASK_RESET[mam_pkg::BIT_LIMIT_HIT];
    else if (i_conv_done && cmp_hit)
      limit_hit_flag <= 1'b1;
    else if (pin_latch_sel && i_reg_rd)
      limit_hit_flag <= 1'b0;
    else if (!pin_latch_sel && i_conv_done)
      limit_hit_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Completion sets ready; a clear in the same cycle loses to it.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      result_ready_flag <= mam_pkg::MASK_RESET[mam_pkg::BIT_RESULT_READY];
    else if (i_conv_done)
      result_ready_flag <= 1'b1;
    else if (i_reg_rd || (i_cfg_wr && !i_cfg_pdown))
      result_ready_flag <= 1'b0;
  end

  // Overflow describes the latest result set, so it is refreshed with it.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      math_overflow_flag <= mam_pkg::MASK_RESET[mam_pkg::BIT_MATH_OVF];
    else if (i_conv_done)
      math_overflow_flag <= i_math_ovf;
  end

  // Storage fault is a read-only mirror of the memory checker.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      storage_fault_flag <= mam_pkg::MASK_RESET[mam_pkg::BIT_STORAGE_FAULT];
    else
      storage_fault_flag <= i_mem_err;
  end

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  // The limit flag and the optional ready indication share the pin.
  assign alert_active = limit_hit_flag || (ready_to_pin_en && result_ready_flag);

  // Normal polarity only pulls low, leaving the high level to the
  // external pull-up; inverted polarity drives both levels.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_alert_o <= mam_pkg::PIN_IDLE_LEVEL;
      o_alert_oe <= 1'b0;
    end
    else if (pin_polarity_sel)
    begin
      o_alert_o <= alert_active;
      o_alert_oe <= 1'b1;
    end
    else
    begin
      o_alert_o <= mam_pkg::PIN_IDLE_LEVEL;
      o_alert_oe <= alert_active;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reserved bits read as zero.
  always_comb
  begin
    next_rdata = 16'h0000;
    next_rdata[mam_pkg::BIT_SHUNT_OVER] = (limit_sel == mam_pkg::MAM_SEL_SHUNT_OVER);
    next_rdata[mam_pkg::BIT_SHUNT_UNDER] = (limit_sel == mam_pkg::MAM_SEL_SHUNT_UNDER);
    next_rdata[mam_pkg::BIT_BUS_OVER] = (limit_sel == mam_pkg::MAM_SEL_BUS_OVER);
    next_rdata[mam_pkg::BIT_BUS_UNDER] = (limit_sel == mam_pkg::MAM_SEL_BUS_UNDER);
    next_rdata[mam_pkg::BIT_POWER_OVER] = (limit_sel == mam_pkg::MAM_SEL_POWER_OVER);
    next_rdata[mam_pkg::BIT_READY_PIN] = ready_to_pin_en;
    next_rdata[mam_pkg::BIT_STORAGE_FAULT] = storage_fault_flag;
    next_rdata[mam_pkg::BIT_LIMIT_HIT] = limit_hit_flag;
    next_rdata[mam_pkg::BIT_RESULT_READY] = result_ready_flag;
    next_rdata[mam_pkg::BIT_MATH_OVF] = math_overflow_flag;
    next_rdata[mam_pkg::BIT_POLARITY] = pin_polarity_sel;
    next_rdata[mam_pkg::BIT_LATCH] = pin_latch_sel;
  end

  // The read value is refreshed every cycle and lags the flags by one.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_reg_rdata <= mam_pkg::MASK_RESET;
    else
      o_reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SHUNT_OVER_HIT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_conv_done && (limit_sel == mam_pkg::MAM_SEL_SHUNT_OVER)
      && ($signed(i_res.shunt) > $signed(i_limit)) |=> limit_hit_flag ##1 o_reg_rdata[mam_pkg::BIT_LIMIT_HIT])
    else $error("Shunt over-limit did not raise the hit flag.");

  AST_SHUNT_UNDER_REFUSED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && i_reg_wdata[mam_pkg::BIT_SHUNT_OVER] |=> limit_sel == mam_pkg::MAM_SEL_SHUNT_OVER)
    else $error("Shunt over enable lost to a lower enable.");

  AST_BUS_OVER_BLOCKED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && !i_reg_wdata[mam_pkg::BIT_SHUNT_OVER] && i_reg_wdata[mam_pkg::BIT_SHUNT_UNDER]
      |=> limit_sel == mam_pkg::MAM_SEL_SHUNT_UNDER)
    else $error("Shunt under enable was not kept over bus enables.");

  AST_BUS_UNDER_BLOCKED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && !i_reg_wdata[mam_pkg::BIT_SHUNT_OVER] && !i_reg_wdata[mam_pkg::BIT_SHUNT_UNDER]
      && i_reg_wdata[mam_pkg::BIT_BUS_OVER] |=> limit_sel == mam_pkg::MAM_SEL_BUS_OVER)
    else $error("Bus over enable was not kept over lower enables.");

  AST_POWER_BLOCKED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_reg_wr && !i_reg_wdata[mam_pkg::BIT_SHUNT_OVER] && !i_reg_wdata[mam_pkg::BIT_SHUNT_UNDER]
      && !i_reg_wdata[mam_pkg::BIT_BUS_OVER] && i_reg_wdata[mam_pkg::BIT_BUS_UNDER]
      |=> limit_sel == mam_pkg::MAM_SEL_BUS_UNDER)
    else $error("Bus under enable was not kept over power enable.");

  AST_READY_ON_PIN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ready_to_pin_en && result_ready_flag && !pin_polarity_sel |=> o_alert_oe && !o_alert_o)
    else $error("Ready flag did not reach the alert pin.");

  AST_ONE_LIMIT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $onehot0(o_reg_rdata[mam_pkg::BIT_SHUNT_OVER:mam_pkg::BIT_POWER_OVER]))
    else $error("More than one limit enable reads back set.");

  AST_LATCH_HOLDS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pin_latch_sel && limit_hit_flag && !i_reg_rd |=> limit_hit_flag)
    else $error("Latched hit flag dropped without a read.");

  AST_TRANSPARENT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !pin_latch_sel && i_conv_done && !cmp_hit |=> !limit_hit_flag)
    else $error("Transparent hit flag stayed after a clean result.");

  AST_READY_SET: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_conv_done |=> result_ready_flag)
    else $error("Completion did not set the ready flag.");

  AST_READY_CLEAR: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_conv_done && (i_reg_rd || (i_cfg_wr && !i_cfg_pdown))
      |=> !result_ready_flag ##1 !o_reg_rdata[mam_pkg::BIT_RESULT_READY])
    else $error("Ready flag survived a clearing access.");

  AST_OVF: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_conv_done && i_math_ovf |=> ##1 o_reg_rdata[mam_pkg::BIT_MATH_OVF])
    else $error("Overflow was not reported.");

  AST_PIN_POLARITY: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pin_polarity_sel && alert_active |=> o_alert_oe && o_alert_o)
    else $error("Inverted polarity did not drive the pin high.");

  COV_LATCHED_READ: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    pin_latch_sel && limit_hit_flag ##1 i_reg_rd ##1 !limit_hit_flag);
  COV_TRANSPARENT_CYCLE: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    !pin_latch_sel && limit_hit_flag ##[1:20] !limit_hit_flag);
  COV_READY_PIN: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    ready_to_pin_en && result_ready_flag && !limit_hit_flag);

endmodule
`default_nettype wire

// ===== dv/mam_host_model.sv
// Host-side model that watches the alert pin through its pull-up.
`timescale 1ns/1ps
`default_nettype none

module mam_host_model
(
  // Pin as driven by the device.
  input wire logic i_pin_o,
  input wire logic i_pin_oe,
  // Polarity the host has programmed.
  input wire logic i_pol,
  // Resolved wire level and decoded alert.
  output logic o_wire,
  output logic o_alert
);
  // A released pin is pulled up, so idle open-drain reads high.
  assign o_wire = i_pin_oe ? i_pin_o : 1'h1;
  // The host decodes the level with the polarity it wrote.
  assign o_alert = i_pol ? o_wire : !o_wire;
endmodule

`default_nettype wire

// ===== dv/mam_alert_tb.sv
// Self-checking bench of the monitor alert mask logic.
`timescale 1ns/1ps
`default_nettype none

module mam_alert_tb;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic cfg_wr = 1'h0;
  logic pdown = 1'h0;
  logic conv = 1'h0;
  logic ovf = 1'h0;
  logic mem_err = 1'h0;
  logic power_over_en = 1'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] limit = 16'h0100;
  logic [15:0] sel;
  logic [15:0] rdata;
  logic pin_o;
  logic pin_oe;
  logic pin_wire;
  logic alert;
  mam_pkg::mam_results_t res = {16'h0100, 16'h0100, 16'h0100};
  mam_pkg::mam_results_t r;
  // Equal-to-limit results never hit, since both compares are strict.
  mam_pkg::mam_results_t quiet = {16'h0100, 16'h0100, 16'h0100};
  // Hit values: the shunt under case is negative to prove a signed compare.
  logic [15:0] hit_v [5] = '{16'h0200, 16'hFF00, 16'h0200, 16'h0080, 16'h0200};
  int err_total = 0;
  int cmp_count = 0;

  // Free-running 50 MHz clock.
  always #10 clk = !clk;

  mam_alert DUT
  (
    .i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cfg_wr(cfg_wr), .i_cfg_pdown(pdown),
    .i_conv_done(conv), .i_res(res), .i_limit(limit), .i_math_ovf(ovf),
    .i_mem_err(mem_err), .o_alert_o(pin_o), .o_alert_oe(pin_oe)
  );

  mam_host_model host
  (
    .i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_pol(power_over_en), .o_wire(pin_wire), .o_alert(alert)
  );

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  // Inputs change only at falling edges, away from the sampling edge.
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write pulse; the readback is settled when the task returns.
  task automatic wr_reg(input logic [15:0] v);
    wr = 1'h1;
    wdata = v;
    step(1);
    wr = 1'h0;
    step(1);
  endtask

  // Read pulse; the word in the next cycle is the value before clearing.
  task automatic rd_reg(input logic [15:0] exp);
    rd = 1'h1;
    step(1);
    rd = 1'h0;
    chk16(rdata, exp);
  endtask

  task automatic do_conv(input mam_pkg::mam_results_t v, input logic o);
    res = v;
    ovf = o;
    conv = 1'h1;
    step(1);
    conv = 1'h0;
  endtask

  // Pin lags the flags by one edge, so look one cycle later.
  task automatic peek(input logic [15:0] exp, input logic exp_alert);
    step(1);
    chk16(rdata, exp);
    chk1(alert, exp_alert);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    step(5);
    arst_n = 1'h1;
    peek(16'h0000, 1'h0);
    // Only the highest limit enable survives; bits 9-2 ignore writes.
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(((16'hF800 >> i) & 16'hF800) | 16'h03FC);
      peek(16'h8000 >> i, 1'h0);
    end
    // Each limit comparison in turn, transparent mode, open-drain pin.
    for (int i = 0; i < 5; i++)
    begin
      sel = 16'h8000 >> i;
      r = quiet;
      if (i < 2)
        r.shunt = hit_v[i];
      else if (i < 4)
        r.bus = hit_v[i];
      else
        r.power = hit_v[i];
      wr_reg(sel);
      do_conv(r, 1'h0);
      peek(sel | 16'h0018, 1'h1);
      rd_reg(sel | 16'h0018);
      peek(sel | 16'h0010, 1'h1);
      do_conv(quiet, 1'h0);
      peek(sel | 16'h0008, 1'h0);
      rd_reg(sel | 16'h0008);
    end
    // Latch is set before the host relies on the alert response.
    power_over_en = 1'h1;
    wr_reg(16'h8003);
    r = quiet;
    r.shunt = 16'h0200;
    do_conv(r, 1'h0);
    peek(16'h801B, 1'h1);
    chk1(pin_oe, 1'h1);
    do_conv(quiet, 1'h0);
    peek(16'h801B, 1'h1);
    rd_reg(16'h801B);
    peek(16'h8003, 1'h0);
    // A hit and a read in one cycle: the set wins, so no event is lost.
    rd = 1'h1;
    do_conv(r, 1'h0);
    rd = 1'h0;
    peek(16'h801B, 1'h1);
    rd_reg(16'h801B);
    peek(16'h8003, 1'h0);
    // Ready flag onto the pin, configuration writes and status flags.
    power_over_en = 1'h0;
    wr_reg(16'h0400);
    do_conv(quiet, 1'h1);
    peek(16'h040C, 1'h1);
    pdown = 1'h1;
    cfg_wr = 1'h1;
    step(1);
    cfg_wr = 1'h0;
    peek(16'h040C, 1'h1);
    pdown = 1'h0;
    cfg_wr = 1'h1;
    step(1);
    cfg_wr = 1'h0;
    peek(16'h0404, 1'h0);
    do_conv(quiet, 1'h0);
    peek(16'h0408, 1'h1);
    mem_err = 1'h1;
    step(1);
    peek(16'h0428, 1'h1);
    // Reset in mid-run returns everything to idle.
    mem_err = 1'h0;
    arst_n = 1'h0;
    step(2);
    arst_n = 1'h1;
    peek(16'h0000, 1'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
